// ===== verilog/irf_defines.svh
`ifndef IRF_DEFINES_SVH
`define IRF_DEFINES_SVH

// Register offsets on the plain register port
`define IRF_ADDR_PIN_EDGE   8'hbf
`define IRF_ADDR_REQ_FLAG   8'hc8
`define IRF_ADDR_IRQ_EN     8'hc9
`define IRF_ADDR_STACK      8'hdf
`define IRF_ADDR_EVT_STAT   8'he0
`define IRF_ADDR_EVT_MASK   8'he1

// Source bit positions, shared by flag, enable, status and mask
`define IRF_BIT_EXT         0
`define IRF_BIT_TMA         4
`define IRF_BIT_TMB         5
`define IRF_BIT_USB         6
`define IRF_SRC_MASK        8'h71

// Stack pointer register fields
`define IRF_BIT_GIE         7
`define IRF_STK_MSB         2
`define IRF_STK_RST         3'h7
`define IRF_GIE_RST         1'b0

// Edge select field of the pin edge register
`define IRF_EDGE_MSB        4
`define IRF_EDGE_LSB        3
`define IRF_EDGE_RST        2'h2

// Generic reset values
`define IRF_BYTE_RST        8'h00

// Program address of the shared interrupt vector
`define IRF_VEC_ADDR        8'h08

`endif

// ===== verilog/irf_pkg.sv
package irf_pkg;

    // Trigger edge choices of the external pin
    typedef enum logic [1:0] {
        IRF_EDGE_RSVD = 2'b00,
        IRF_EDGE_RISE = 2'b01,
        IRF_EDGE_FALL = 2'b10,
        IRF_EDGE_BOTH = 2'b11
    } irf_edge_e;

    // Service state of the sequencer handshake
    typedef enum logic [0:0] {
        IRF_SVC_IDLE = 1'b0,
        IRF_SVC_BUSY = 1'b1
    } irf_svc_e;

    // Byte-wide register data
    typedef logic [7:0] irf_byte_t;

endpackage : irf_pkg

// ===== verilog/irf_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Pin synchroniser with edge pulses
module irf_pin_sync (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    // Asynchronous pin
    input  wire logic i_pin,
    // Edge pulses, one cycle each
    output logic      o_rise,
    output logic      o_fall
);

    logic meta;   // First stage, read only by the second
    logic sync;   // Second stage, safe to use
    logic prev;   // Previous safe sample

    // Two flops before anything looks at the pin
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= i_pin;
            sync <= meta;
            prev <= sync;
        end
    end

    // Compare successive safe samples
    assign o_rise = sync & ~prev;
    assign o_fall = ~sync & prev;

endmodule : irf_pin_sync

`default_nettype wire

// ===== verilog/irf_flag_logic.sv
// Overview of operation
// - Pin trigger sets external flag regardless enable
// - Enabled external flag vectors to address eight
// - Disabled external source sets flag, no vector
// - Matching wake edge latches external flag
// - Latched wake request vectors right away
// - Edge field selects rise, fall, both
// - First timer overflow always sets its flag
// - First timer vectors only when enabled
// - Second timer overflow sets flag, vectors if enabled
// - Second timer disabled sets flag only
// - USB done sets flag, vectors if enabled
// - USB disabled sets flag only
// - No vector without global enable set
// - Entry clears global enable, return sets it
`include "irf_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module irf_flag_logic (
    // Clock and reset
    input  wire logic            i_sys_clk,
    input  wire logic            i_rst_n,
    // Register port
    input  wire logic [7:0]      i_addr,
    input  wire irf_pkg::irf_byte_t i_wdata,
    input  wire logic            i_wr,
    input  wire logic            i_rd,
    output irf_pkg::irf_byte_t   o_rdata,
    // Interrupt sources
    input  wire logic            i_ext_pin,
    input  wire logic            i_timer_a_ovf,
    input  wire logic            i_timer_b_ovf,
    input  wire logic            i_usb_done,
    // Low power state
    input  wire logic            i_sleep_mode,
    input  wire logic            i_wake_on_fall,
    output logic                 o_wake,
    // Program sequencer handshake
    input  wire logic            i_reti,
    output logic                 o_vector_req,
    output logic [7:0]           o_vector_addr,
    // Event interrupt line
    output logic                 o_irq
);

    import irf_pkg::*;

    // Edge match for a given selection
    function automatic logic edge_hit(input irf_edge_e sel,
                                      input logic rise,
                                      input logic fall);
        logic hit;
        hit = 1'b0;
        case (sel)
            IRF_EDGE_RISE: hit = rise;
            IRF_EDGE_FALL: hit = fall;
            IRF_EDGE_BOTH: hit = rise | fall;
            default:       hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_hit

    // Register state
    irf_byte_t request_flag_reg;    // Sticky request flags
    irf_byte_t irq_enable;          // Per-source enables
    logic      global_irq_enable;   // Global enable bit
    logic [2:0] stack_pointer_reg;  // Stack level bits
    irf_edge_e edge_select_field;   // Pin trigger choice
    irf_byte_t evt_stat;            // Read-clear event status
    irf_byte_t evt_mask;            // Event line mask
    irf_svc_e  svc_state;           // Service state

    // Pin edges from the synchroniser
    logic pin_rise;
    logic pin_fall;

    irf_pin_sync u_pin_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_pin     (i_ext_pin),
        .o_rise    (pin_rise),
        .o_fall    (pin_fall)
    );

    // Address decode
    wire wr_edge  = i_wr && (i_addr == `IRF_ADDR_PIN_EDGE);
    wire wr_flag  = i_wr && (i_addr == `IRF_ADDR_REQ_FLAG);
    wire wr_en    = i_wr && (i_addr == `IRF_ADDR_IRQ_EN);
    wire wr_stack = i_wr && (i_addr == `IRF_ADDR_STACK);
    wire wr_mask  = i_wr && (i_addr == `IRF_ADDR_EVT_MASK);
    wire rd_stat  = i_rd && (i_addr == `IRF_ADDR_EVT_STAT);

    // Awake trigger on the selected edge
    wire awake_trig = ~i_sleep_mode &
                      edge_hit(edge_select_field, pin_rise, pin_fall);

    // Wake edge in the wake-up direction
    wire wake_hit = i_sleep_mode &
                    (i_wake_on_fall ? pin_fall : pin_rise);

    // Latch only when interrupt and wake directions agree
    wire ext_pin_req_latch = wake_hit &
        edge_hit(edge_select_field, pin_rise & ~i_wake_on_fall,
                 pin_fall & i_wake_on_fall);

    // External pin source event
    wire external_pin_interrupt = awake_trig | ext_pin_req_latch;

    // Source events in flag layout
    irf_byte_t src_evt;
    always_comb begin
        src_evt = `IRF_BYTE_RST;
        src_evt[`IRF_BIT_EXT] = external_pin_interrupt;
        src_evt[`IRF_BIT_TMA] = i_timer_a_ovf;
        src_evt[`IRF_BIT_TMB] = i_timer_b_ovf;
        src_evt[`IRF_BIT_USB] = i_usb_done;
    end

    // Flags: set wins over a software clear
    wire irf_byte_t next_request_flag =
        ((wr_flag ? i_wdata : request_flag_reg) | src_evt) &
        `IRF_SRC_MASK;

    // Enables are independent of flag setting
    wire irf_byte_t next_irq_enable =
        (wr_en ? i_wdata : irq_enable) & `IRF_SRC_MASK;

    // Any enabled flag pending; one vector
    wire any_enabled = |(request_flag_reg & irq_enable);

    // Vector only with global enable and idle
    wire take_vector = global_irq_enable & any_enabled &
                       (svc_state == IRF_SVC_IDLE);

    // Return from service
    wire svc_return = i_reti & (svc_state == IRF_SVC_BUSY);

    // Global enable: entry clears, return sets
    wire next_gie = take_vector ? 1'b0 :
                    svc_return  ? 1'b1 :
                    wr_stack    ? i_wdata[`IRF_BIT_GIE] :
                                  global_irq_enable;

    // Next service state
    irf_svc_e next_svc_state;
    always_comb begin
        next_svc_state = svc_state;
        case (svc_state)
            IRF_SVC_IDLE: begin
                if (take_vector) begin
                    next_svc_state = IRF_SVC_BUSY;
                end
            end
            IRF_SVC_BUSY: begin
                if (i_reti) begin
                    next_svc_state = IRF_SVC_IDLE;
                end
            end
            default: next_svc_state = IRF_SVC_IDLE;
        endcase
    end

    // Event status: read clears, a new event still wins
    wire irf_byte_t next_evt_stat =
        ((rd_stat ? `IRF_BYTE_RST : evt_stat) | src_evt) &
        `IRF_SRC_MASK;

    // Mask of the event line
    wire irf_byte_t next_evt_mask =
        (wr_mask ? i_wdata : evt_mask) & `IRF_SRC_MASK;

    // Read data selection, unmapped reads return zero
    irf_byte_t stack_view;
    irf_byte_t edge_view;
    irf_byte_t rd_mux;
    always_comb begin
        stack_view = `IRF_BYTE_RST;
        stack_view[`IRF_BIT_GIE] = global_irq_enable;
        stack_view[`IRF_STK_MSB:0] = stack_pointer_reg;
        edge_view = `IRF_BYTE_RST;
        edge_view[`IRF_EDGE_MSB:`IRF_EDGE_LSB] = edge_select_field;
    end

    assign rd_mux =
        (i_addr == `IRF_ADDR_PIN_EDGE) ? edge_view :
        (i_addr == `IRF_ADDR_REQ_FLAG) ? request_flag_reg :
        (i_addr == `IRF_ADDR_IRQ_EN)   ? irq_enable :
        (i_addr == `IRF_ADDR_STACK)    ? stack_view :
        (i_addr == `IRF_ADDR_EVT_STAT) ? evt_stat :
        (i_addr == `IRF_ADDR_EVT_MASK) ? evt_mask :
                                         `IRF_BYTE_RST;

    // Source flags and enables
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            request_flag_reg <= `IRF_BYTE_RST;
            irq_enable       <= `IRF_BYTE_RST;
        end else begin
            request_flag_reg <= next_request_flag;
            irq_enable       <= next_irq_enable;
        end
    end

    // Stack register and pin edge register
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            global_irq_enable <= `IRF_GIE_RST;
            stack_pointer_reg <= `IRF_STK_RST;
            edge_select_field <= irf_edge_e'(`IRF_EDGE_RST);
        end else begin
            global_irq_enable <= next_gie;
            if (wr_stack) begin
                stack_pointer_reg <= i_wdata[`IRF_STK_MSB:0];
            end
            if (wr_edge) begin
                edge_select_field <=
                    irf_edge_e'(i_wdata[`IRF_EDGE_MSB:`IRF_EDGE_LSB]);
            end
        end
    end

    // Service state and sequencer outputs
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            svc_state     <= IRF_SVC_IDLE;
            o_vector_req  <= 1'b0;
            o_vector_addr <= `IRF_VEC_ADDR;
        end else begin
            svc_state     <= next_svc_state;
            o_vector_req  <= take_vector;
            o_vector_addr <= `IRF_VEC_ADDR;
        end
    end

    // Wake pulse; an early vector follows the latch
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_wake <= 1'b0;
        end else begin
            o_wake <= wake_hit;
        end
    end

    // Event status, mask and interrupt line
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            evt_stat <= `IRF_BYTE_RST;
            evt_mask <= `IRF_BYTE_RST;
            o_irq    <= 1'b0;
        end else begin
            evt_stat <= next_evt_stat;
            evt_mask <= next_evt_mask;
            o_irq    <= |(next_evt_stat & next_evt_mask);
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_rdata <= `IRF_BYTE_RST;
        end else begin
            o_rdata <= i_rd ? rd_mux : `IRF_BYTE_RST;
        end
    end

    // Checks, all in the system clock domain
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    // Awake trigger sets the external flag
    AST_EXT_FLAG_SET: assert property (
        awake_trig |=> request_flag_reg[`IRF_BIT_EXT])
        else $error("external flag not set after pin trigger");

    // Enabled pending flag with global enable vectors to eight
    AST_EXT_VECTOR: assert property (
        (global_irq_enable && svc_state == IRF_SVC_IDLE &&
         request_flag_reg[`IRF_BIT_EXT] && irq_enable[`IRF_BIT_EXT])
        |=> o_vector_req && o_vector_addr == `IRF_VEC_ADDR)
        else $error("enabled external request did not vector");

    // No enabled flag means no vector
    AST_NO_VECTOR_DISABLED: assert property (
        (request_flag_reg & irq_enable) == `IRF_BYTE_RST
        |=> !o_vector_req)
        else $error("vector without an enabled pending flag");

    // Matching wake edge latches the flag
    AST_WAKE_LATCH: assert property (
        ext_pin_req_latch |=> request_flag_reg[`IRF_BIT_EXT])
        else $error("wake edge did not latch external flag");

    // Latched wake request vectors two to three cycles later
    AST_WAKE_VECTOR: assert property (
        (ext_pin_req_latch && irq_enable[`IRF_BIT_EXT] &&
         global_irq_enable && svc_state == IRF_SVC_IDLE && !i_wr)
        |=> ##[1:2] o_vector_req)
        else $error("wake latch not followed by a vector");

    // Reserved edge code never raises the flag while awake
    AST_RSVD_EDGE: assert property (
        (edge_select_field == IRF_EDGE_RSVD && !i_sleep_mode &&
         !request_flag_reg[`IRF_BIT_EXT] && !wr_flag)
        |=> !request_flag_reg[`IRF_BIT_EXT])
        else $error("reserved edge code raised the flag");

    // Timer and USB events set their flags
    AST_TMA_FLAG: assert property (
        i_timer_a_ovf |=> request_flag_reg[`IRF_BIT_TMA])
        else $error("first timer flag not set");

    AST_TMB_FLAG: assert property (
        $rose(i_timer_b_ovf) |=> $past(src_evt[`IRF_BIT_TMB]) &&
                                 request_flag_reg[`IRF_BIT_TMB])
        else $error("second timer flag not set");

    AST_USB_FLAG: assert property (
        i_usb_done ##1 !wr_flag |-> request_flag_reg[`IRF_BIT_USB])
        else $error("usb flag not set");

    // Disabled sources alone never vector
    AST_DIS_SRC_NOVEC: assert property (
        (irq_enable == `IRF_BYTE_RST) |=> !o_vector_req)
        else $error("vector with all sources disabled");

    // Global enable off forbids vectoring
    AST_GIE_GATE: assert property (
        !global_irq_enable |=> !o_vector_req)
        else $error("vector with global enable clear");

    // Entry clears and return sets the global enable
    AST_GIE_ENTRY: assert property (
        o_vector_req |-> !global_irq_enable &&
                         svc_state == IRF_SVC_BUSY)
        else $error("global enable not cleared on entry");

    AST_GIE_RETURN: assert property (
        svc_return |=> global_irq_enable)
        else $error("global enable not set on return");

    // No vector request in the cycle right after a vector request
    AST_SINGLE_VECTOR: assert property (
        o_vector_req |-> ##1 !o_vector_req)
        else $error("vector repeated without a return");

    // Main scenarios
    COV_EXT_VECTOR: cover property (awake_trig ##[1:3] o_vector_req);
    COV_WAKE_LATCH: cover property (ext_pin_req_latch ##[1:3] o_vector_req);
    COV_MULTI_PEND: cover property ($countones(request_flag_reg) > 1
                                     ##1 o_vector_req);
    COV_RETURN:     cover property (o_vector_req ##[1:40] svc_return);

endmodule : irf_flag_logic

`default_nettype wire

// ===== tb/irf_seq_model.sv
`timescale 1ns/1ps
`default_nettype none

// Sequencer stand-in: takes a vector, runs a service, then returns
module irf_seq_model (
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    // Vector side of the flag logic
    input  wire logic       i_vector_req,
    // Service length in cycles, sampled at entry
    input  wire logic [7:0] i_delay,
    // Return pulse and vector tally
    output logic            o_reti,
    output logic [7:0]      o_vec_cnt
);
    logic       busy;     // Inside a service routine
    logic [7:0] wait_cnt; // Cycles left before return

    // Service timer; a long delay gives software room to clear flags
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            busy      <= 1'b0;
            wait_cnt  <= 8'h00;
            o_reti    <= 1'b0;
            o_vec_cnt <= 8'h00;
        end else if (i_vector_req) begin
            busy      <= 1'b1;
            wait_cnt  <= i_delay;
            o_reti    <= 1'b0;
            o_vec_cnt <= o_vec_cnt + 8'h01;
        end else begin
            // Return pulse re-opens the global enable
            o_reti    <= busy && (wait_cnt == 8'h00);
            busy      <= busy && (wait_cnt != 8'h00);
            wait_cnt  <= (wait_cnt != 8'h00) ? wait_cnt - 8'h01 : 8'h00;
        end
    end
endmodule : irf_seq_model

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import irf_pkg::*;
    // Bench-driven inputs
    logic       i_sys_clk, i_rst_n, i_wr, i_rd, i_ext_pin;
    logic       i_timer_a_ovf, i_timer_b_ovf, i_usb_done;
    logic       i_sleep_mode, i_wake_on_fall;
    logic [7:0] i_addr, i_delay;
    irf_byte_t  i_wdata;
    // Design outputs and partner wires
    irf_byte_t  o_rdata;
    logic       o_wake, o_vector_req, o_irq, reti;
    logic [7:0] o_vector_addr, vec_cnt;
    // Scoreboard state
    logic [7:0] exp_q[$];
    logic       rd_pend  = 1'b0;
    int         wake_cnt = 0;
    int         error_cnt = 0;
    int         num_checks = 0;
    int         exp_vec = 0;
    logic [2:0] s;
    int         seed;

    irf_flag_logic u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_ext_pin(i_ext_pin),
        .i_timer_a_ovf(i_timer_a_ovf), .i_timer_b_ovf(i_timer_b_ovf),
        .i_usb_done(i_usb_done), .i_sleep_mode(i_sleep_mode),
        .i_wake_on_fall(i_wake_on_fall), .o_wake(o_wake), .i_reti(reti),
        .o_vector_req(o_vector_req), .o_vector_addr(o_vector_addr),
        .o_irq(o_irq));

    irf_seq_model u_seq (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_vector_req(o_vector_req), .i_delay(i_delay), .o_reti(reti),
        .o_vec_cnt(vec_cnt));

    // Free-running 200 MHz clock
    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end

    task automatic stop_test();
        if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : tick

    // One-cycle write strobe, then one idle cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        tick(1);
        i_wr    <= 1'b0;
        tick(1);
    endtask : wr

    // Read strobe; the monitor compares the data a cycle later
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_addr <= a;
        i_rd   <= 1'b1;
        tick(1);
        i_rd   <= 1'b0;
        tick(1);
    endtask : rd

    // Pulse a set of counter sources: bit0 timer a, bit1 timer b, bit2 usb
    task automatic fire(input logic [2:0] src);
        {i_usb_done, i_timer_b_ovf, i_timer_a_ovf} <= src;
        tick(1);
        {i_usb_done, i_timer_b_ovf, i_timer_a_ovf} <= 3'b000;
        tick(2);
    endtask : fire

    // Pin change, long enough for the synchroniser to report it
    task automatic pin(input logic v);
        i_ext_pin <= v;
        tick(6);
    endtask : pin

    // Compare tallies at the falling edge, where every update has landed
    task automatic counts(input int w);
        tick(4);
        @(negedge i_sys_clk);
        check(vec_cnt, exp_vec[7:0]);
        check(wake_cnt[7:0], w[7:0]);
        check({7'h00, o_irq}, 8'h00);
        tick(1);
    endtask : counts

    // Result monitor: read data, vector address, wake pulses
    always @(posedge i_sys_clk) begin
        if (rd_pend) check(o_rdata, exp_q.pop_front());
        if (o_vector_req) check(o_vector_addr, 8'h08);
        if (o_wake) wake_cnt <= wake_cnt + 1;
        rd_pend <= i_rd;
    end

    // Watchdog well beyond the expected run length
    initial begin
        #100000;
        error_cnt++;
        stop_test();
    end

    initial begin
        {i_wr, i_rd, i_ext_pin, i_sleep_mode, i_wake_on_fall} = 5'b00000;
        {i_timer_a_ovf, i_timer_b_ovf, i_usb_done} = 3'b000;
        {i_addr, i_wdata, i_delay} = {8'h00, 8'h00, 8'd30};
        i_rst_n = 1'b0;
        seed = $urandom(2);
        tick(6);
        i_rst_n <= 1'b1;
        // Reset values, unused bits and an unmapped address
        rd(8'hbf, 8'h10);
        rd(8'hc8, 8'h00);
        rd(8'hdf, 8'h07);
        rd(8'he1, 8'h00);
        wr(8'hc9, 8'hff);
        rd(8'hc9, 8'h71);
        wr(8'hc9, 8'h00);
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00);
        // Event status, mask and level output
        wr(8'he1, 8'h10);
        fire(3'b001);
        @(negedge i_sys_clk);
        check({7'h00, o_irq}, 8'h01);
        // Back onto the rising edge before driving again
        tick(1);
        fire(3'b010);
        rd(8'he0, 8'h30);
        rd(8'he0, 8'h00);
        wr(8'he1, 8'h00);
        rd(8'hc8, 8'h30);
        wr(8'hc8, 8'h00);
        // Each counter source disabled, then enabled
        for (int i = 0; i < 3; i++) begin
            wr(8'hc9, 8'h00);
            wr(8'hdf, 8'h87);
            fire(3'b001 << i);
            counts(0);
            rd(8'hc8, 8'h10 << i);
            wr(8'hc8, 8'h00);
            wr(8'hc9, 8'h10 << i);
            fire(3'b001 << i);
            exp_vec++;
            counts(0);
            rd(8'hdf, 8'h07);
            wr(8'hc8, 8'h00);
            tick(40);
            rd(8'hdf, 8'h87);
        end
        // Pending sources held off by global enable, then one vector
        wr(8'hdf, 8'h07);
        wr(8'hc9, 8'h71);
        fire(3'b111);
        counts(0);
        wr(8'hdf, 8'h87);
        exp_vec++;
        counts(0);
        rd(8'hc8, 8'h70);
        wr(8'hc8, 8'h00);
        tick(40);
        counts(0);
        // Every edge code on the pin, source disabled
        wr(8'hc9, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(8'hbf, c[1:0] << 3);
            rd(8'hbf, c[1:0] << 3);
            pin(1'b1);
            rd(8'hc8, {7'h00, c[0]});
            wr(8'hc8, 8'h00);
            pin(1'b0);
            rd(8'hc8, {7'h00, c[1]});
            wr(8'hc8, 8'h00);
        end
        counts(0);
        // Pin source enabled, rising edge only
        wr(8'hc9, 8'h01);
        wr(8'hbf, 8'h08);
        pin(1'b1);
        exp_vec++;
        counts(0);
        wr(8'hc8, 8'h00);
        tick(40);
        pin(1'b0);
        rd(8'hc8, 8'h00);
        // Sleep: wake edge outside the select latches nothing
        i_sleep_mode   <= 1'b1;
        i_wake_on_fall <= 1'b1;
        pin(1'b1);
        pin(1'b0);
        rd(8'hc8, 8'h00);
        counts(1);
        // Sleep: matching falling edge latches and vectors at once
        wr(8'hbf, 8'h10);
        pin(1'b1);
        pin(1'b0);
        exp_vec++;
        counts(2);
        rd(8'hc8, 8'h01);
        i_sleep_mode <= 1'b0;
        wr(8'hc8, 8'h00);
        tick(40);
        // Sleep: rising wake direction with both edges selected
        wr(8'hbf, 8'h18);
        i_sleep_mode   <= 1'b1;
        i_wake_on_fall <= 1'b0;
        pin(1'b1);
        exp_vec++;
        counts(3);
        // Falling edge is no wake edge now, flag only holds
        pin(1'b0);
        rd(8'hc8, 8'h01);
        i_sleep_mode <= 1'b0;
        wr(8'hc8, 8'h00);
        tick(40);
        // Random source mixes, all disabled
        wr(8'hc9, 8'h00);
        repeat (8) begin
            s = 3'($urandom_range(7));
            fire(s);
            rd(8'hc8, {1'b0, s, 4'h0});
            wr(8'hc8, 8'h00);
        end
        counts(3);
        tick(2);
        stop_test();
    end
endmodule : tb

`default_nettype wire
